// file: hw/tmc_pkg.sv
// constants, register map and field layouts of the eight-bit timer/counter
package tmc_pkg;
   // clock and instruction-cycle rate
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned INSTR_PERIOD_NS = 40;
   localparam int unsigned INSTR_DIV = INSTR_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);
   localparam logic [1:0] WRITE_INHIBIT_CYCLES = 2'h2;

   // register indices; byte address is four times the index
   localparam int unsigned ADDR_W = 12;
   localparam logic [7:0] IDX_TIMER_COUNT = 8'h01;
   localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0b;
   localparam logic [7:0] IDX_OPTION_CONFIG = 8'h81;

   // reset values and count maximum
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] INTCTL_RESET = 8'h00;
   localparam logic [7:0] OPTION_RESET = 8'hff;
   localparam logic [7:0] COUNT_MAX = 8'hff;

   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic port_pullup_disable;
      logic ext_irq_edge;
      logic clock_source_select;
      logic source_edge_select;
      logic prescaler_assign;
      logic prescale_select_hi;
      logic prescale_select_mid;
      logic prescale_select_lo;
   } tmc_option_t;

   typedef struct packed {
      logic global_irq_enable;
      logic peripheral_irq_enable;
      logic overflow_irq_enable;
      logic ext_irq_enable;
      logic port_change_irq_enable;
      logic overflow_flag;
      logic ext_irq_flag;
      logic port_change_flag;
   } tmc_intctl_t;
endpackage : tmc_pkg

// file: hw/tmc_timer.sv
// eight-bit timer/counter with shared prescaler behind an axi4-lite slave
// Function
// - timer mode: count advances once per instruction cycle without prescaler
// - a count write holds counting off for two instruction cycles
// - counter mode: count advances on external count input edges
// - edge select: cleared counts rising, set counts falling edges
// - one prescaler, assigned to timer or watchdog, never both
// - prescaler count is neither readable nor writable by software
// - prescaler is an eight-bit divider chosen by option select bits
// - wrap from maximum to zero sets the overflow flag
// - overflow request raised only while overflow enable is set
// - sleep halts the timer, so no overflow occurs
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module tmc_timer
   import tmc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sleep_active,
   input wire logic external_count_input,
   input wire logic watchdog_tick_in,
   output logic watchdog_prescaled,
   output logic overflow_irq
);
   // bus-side state
   logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
   logic [ADDR_W-1:0] waddr_q, waddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic wstrb0_q, wstrb0_d;
   logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
   logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   // timer state
   logic [7:0] count_q, count_d, presc_q, presc_d;
   tmc_option_t opt_q, opt_d;
   tmc_intctl_t ictl_q, ictl_d;
   logic [1:0] instr_cnt_q, instr_cnt_d, inhibit_q, inhibit_d;
   logic ext_s1_q, ext_s2_q, ext_s3_q, ext_lvl_q, ext_lvl_d, ext_prev_q;
   logic wd_out_q, wd_out_d, irq_q, irq_d;
   // combinational helpers
   logic wr_fire, wr_cnt, wr_ictl, wr_opt, wr_hit, instr_en, ext_evt;
   logic timer_src, presc_evt, presc_out, inc, assign_wd;
   logic [2:0] ps;
   logic [8:0] shifted;
   logic [7:0] mask;

   function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      reg_hit = (a[ADDR_W-1:10] == '0) && (a[9:2] == idx);
   endfunction : reg_hit

   // external pin synchroniser; only the second stage reads the first
   always_ff @(posedge aclk)
   begin
      ext_s1_q <= external_count_input;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
   end

   // decode and event sources
   always_comb
   begin
      wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
      wr_hit = reg_hit(waddr_q, IDX_TIMER_COUNT) || reg_hit(waddr_q, IDX_INTERRUPT_CONTROL)
         || reg_hit(waddr_q, IDX_OPTION_CONFIG);
      wr_cnt = wr_fire && wstrb0_q && reg_hit(waddr_q, IDX_TIMER_COUNT);
      wr_ictl = wr_fire && wstrb0_q && reg_hit(waddr_q, IDX_INTERRUPT_CONTROL);
      wr_opt = wr_fire && wstrb0_q && reg_hit(waddr_q, IDX_OPTION_CONFIG);
      instr_en = (instr_cnt_q == INSTR_LAST);
      // level changes only once stages two and three agree
      ext_lvl_d = (ext_s2_q == ext_s3_q) ? ext_s3_q : ext_lvl_q;
      ext_evt = opt_q.source_edge_select ? (ext_prev_q && !ext_lvl_q)
         : (!ext_prev_q && ext_lvl_q);
      timer_src = opt_q.clock_source_select ? ext_evt : instr_en;
      assign_wd = opt_q.prescaler_assign;
      ps = {opt_q.prescale_select_hi, opt_q.prescale_select_mid, opt_q.prescale_select_lo};
      // timer ratio 2^(ps+1), watchdog ratio 2^ps
      shifted = assign_wd ? (9'h001 << ps) : (9'h002 << ps);
      mask = 8'(shifted - 9'h001);
      presc_evt = assign_wd ? watchdog_tick_in : (timer_src && !sleep_active);
      presc_out = presc_evt && ((presc_q | ~mask) == 8'hff);
      inc = (assign_wd ? timer_src : presc_out) && !sleep_active
         && (inhibit_q == 2'h0) && !wr_cnt;
   end

   // next timer state; hardware set of the flag beats a software clear
   always_comb
   begin
      instr_cnt_d = instr_en ? 2'h0 : instr_cnt_q + 2'h1;
      count_d = count_q;
      presc_d = presc_evt ? presc_q + 8'h01 : presc_q;
      opt_d = wr_opt ? tmc_option_t'(wdata_q[7:0]) : opt_q;
      ictl_d = wr_ictl ? tmc_intctl_t'(wdata_q[7:0]) : ictl_q;
      inhibit_d = inhibit_q;
      if (wr_cnt)
      begin
         count_d = wdata_q[7:0];
         inhibit_d = WRITE_INHIBIT_CYCLES;
         if (!assign_wd)
            presc_d = 8'h00; // count write restarts a timer-assigned prescaler
      end
      else
      begin
         if (inhibit_q != 2'h0 && instr_en && !sleep_active)
            inhibit_d = inhibit_q - 2'h1;
         if (inc)
            count_d = count_q + 8'h01;
      end
      if (inc && count_q == COUNT_MAX)
         ictl_d.overflow_flag = 1'b1;
      irq_d = ictl_d.overflow_flag && ictl_d.overflow_irq_enable;
      // undivided tick passes when the prescaler belongs to the timer
      wd_out_d = assign_wd ? presc_out : watchdog_tick_in;
   end

   // next bus state; one write and one read at a time
   always_comb
   begin
      aw_hold_d = aw_hold_q;
      w_hold_d = w_hold_q;
      waddr_d = waddr_q;
      wdata_d = wdata_q;
      wstrb0_d = wstrb0_q;
      bvalid_d = bvalid_q && !s_axi_bready;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q && !s_axi_rready;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      if (s_axi_awvalid && awready_q)
      begin
         aw_hold_d = 1'b1;
         waddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q)
      begin
         w_hold_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb0_d = s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
         aw_hold_d = 1'b0;
         w_hold_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_arvalid && arready_q)
      begin
         rvalid_d = 1'b1;
         rresp_d = RESP_OKAY;
         // prescaler has no address, so its count never reaches software
         if (reg_hit(s_axi_araddr, IDX_TIMER_COUNT))
            rdata_d = {24'h000000, count_q};
         else if (reg_hit(s_axi_araddr, IDX_INTERRUPT_CONTROL))
            rdata_d = {24'h000000, ictl_q};
         else if (reg_hit(s_axi_araddr, IDX_OPTION_CONFIG))
            rdata_d = {24'h000000, opt_q};
         else
         begin
            rdata_d = 32'h00000000;
            rresp_d = RESP_SLVERR;
         end
      end
      awready_d = !aw_hold_d;
      wready_d = !w_hold_d;
      arready_d = !rvalid_d;
   end

   // registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         waddr_q <= '0;
         wdata_q <= 32'h00000000;
         wstrb0_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         arready_q <= 1'b0;
         bvalid_q <= 1'b0;
         rvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         rresp_q <= RESP_OKAY;
         rdata_q <= 32'h00000000;
         count_q <= COUNT_RESET;
         presc_q <= 8'h00;
         opt_q <= OPTION_RESET;
         ictl_q <= INTCTL_RESET;
         instr_cnt_q <= 2'h0;
         inhibit_q <= 2'h0;
         ext_lvl_q <= 1'b0;
         ext_prev_q <= 1'b0;
         wd_out_q <= 1'b0;
         irq_q <= 1'b0;
      end
      else
      begin
         aw_hold_q <= aw_hold_d;
         w_hold_q <= w_hold_d;
         waddr_q <= waddr_d;
         wdata_q <= wdata_d;
         wstrb0_q <= wstrb0_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         arready_q <= arready_d;
         bvalid_q <= bvalid_d;
         rvalid_q <= rvalid_d;
         bresp_q <= bresp_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
         count_q <= count_d;
         presc_q <= presc_d;
         opt_q <= opt_d;
         ictl_q <= ictl_d;
         instr_cnt_q <= instr_cnt_d;
         inhibit_q <= inhibit_d;
         ext_lvl_q <= ext_lvl_d;
         ext_prev_q <= ext_lvl_q;
         wd_out_q <= wd_out_d;
         irq_q <= irq_d;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;
   assign watchdog_prescaled = wd_out_q;
   assign overflow_irq = irq_q;

   // checks
   sequence count_write_s;
      wr_cnt;
   endsequence
   sequence quiet_instr_s;
      !wr_cnt && !sleep_active;
   endsequence

   property inhibit_load_p;
      @(posedge aclk) disable iff (!aresetn)
      count_write_s |=> (inhibit_q == WRITE_INHIBIT_CYCLES) && (count_q == $past(wdata_q[7:0]));
   endproperty
   write_inhibit_load_a: assert property (inhibit_load_p)
      else $error("count write did not load value and inhibit");

   inhibit_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (inhibit_q != 2'h0) && !wr_cnt |=> $stable(count_q))
      else $error("count moved while inhibited");

   timer_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ((!opt_q.clock_source_select && assign_wd && instr_en && inhibit_q == 2'h0)
      and quiet_instr_s) |=> count_q == $past(count_q) + 8'h01)
      else $error("timer mode missed an instruction-cycle step");

   counter_no_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
      opt_q.clock_source_select && assign_wd && !ext_evt && !wr_cnt |=> $stable(count_q))
      else $error("counter mode moved without an edge");

   overflow_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      inc && count_q == COUNT_MAX |=> ictl_q.overflow_flag && count_q == 8'h00)
      else $error("wrap did not set overflow flag");

   irq_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !ictl_q.overflow_irq_enable |-> !overflow_irq)
      else $error("overflow request while masked");

   sleep_halt_a: assert property (@(posedge aclk) disable iff (!aresetn)
      // a software write may set the flag by hand, so it is left out here
      sleep_active && !wr_cnt && !wr_ictl |=> $stable(count_q) ##0 !$rose(ictl_q.overflow_flag))
      else $error("timer moved during sleep");

   watchdog_bypass_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !assign_wd && watchdog_tick_in |=> watchdog_prescaled)
      else $error("watchdog tick lost while prescaler on timer");

   sync_agree_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ext_lvl_q != $past(ext_lvl_q) |-> $past(ext_s2_q) == $past(ext_s3_q))
      else $error("external level changed without agreement");

   write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire |=> s_axi_bvalid)
      else $error("write response missing");

   // response stays put until the master takes it
   bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
endmodule : tmc_timer

// file: tb/tmc_timer_bench.sv
// self-checking bench for the eight-bit timer/counter over axi4-lite
`timescale 1ns/1ps
module tmc_timer_bench
   import tmc_pkg::*;
();
   localparam logic [ADDR_W-1:0] A_CNT = ADDR_W'({IDX_TIMER_COUNT, 2'b00});
   localparam logic [ADDR_W-1:0] A_INT = ADDR_W'({IDX_INTERRUPT_CONTROL, 2'b00});
   localparam logic [ADDR_W-1:0] A_OPT = ADDR_W'({IDX_OPTION_CONFIG, 2'b00});
   localparam logic [ADDR_W-1:0] A_BAD = 12'h3fc;
   logic aclk, aresetn;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic sleep_active, external_count_input, watchdog_tick_in;
   logic watchdog_prescaled, overflow_irq;
   logic [7:0] rd;
   int bad_count = 0;
   int num_checks = 0;
   int wd_pulses = 0;
   int base;

   tmc_timer uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_active,
      .external_count_input, .watchdog_tick_in, .watchdog_prescaled, .overflow_irq);

   // free-running 100 mhz clock
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // tally of watchdog pulses leaving the prescaler
   always @(posedge aclk)
      if (watchdog_prescaled === 1'b1) wd_pulses <= wd_pulses + 1;

   task results();
      if (bad_count == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results

   task check(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // phase of the instruction divider is unknown, so allow a small window
   task near(input string what, input logic [7:0] lo, input logic [7:0] hi);
      num_checks++;
      if (^rd === 1'bx || rd < lo || rd > hi)
      begin
         bad_count++;
         $display("Error %s expected %h..%h seen %h", what, lo, hi, rd);
      end
   endtask : near

   // both channels offered together, each released once taken
   task wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] s);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge aclk);
         if (!aw_ok && s_axi_awready === 1'b1)
         begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1)
         begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
      // one edge between calls so bready is never set twice in a time step
      @(posedge aclk);
   endtask : wr

   task rdr(input logic [ADDR_W-1:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata[7:0];
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : rdr

   // one-cycle ticks, spaced four cycles apart
   task ticks(input int n);
      repeat (n)
      begin
         watchdog_tick_in <= 1'b1;
         @(posedge aclk);
         watchdog_tick_in <= 1'b0;
         repeat (3) @(posedge aclk);
      end
      repeat (4) @(posedge aclk);
   endtask : ticks

   // slow pin steps leave room for the synchroniser latency
   task pins();
      repeat (12) @(posedge aclk);
      for (int i = 0; i < 7; i++)
      begin
         external_count_input <= ~i[0];
         repeat (12) @(posedge aclk);
      end
      external_count_input <= 1'b0;
      repeat (12) @(posedge aclk);
   endtask : pins

   // watchdog on the whole run; tests need roughly 900 cycles
   initial
   begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      results();
   end

   // main sequence
   initial
   begin
      {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_wdata, s_axi_wstrb} = '0;
      {sleep_active, external_count_input, watchdog_tick_in} = 3'b000;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rdr(A_OPT);
      check("option_config", OPTION_RESET, rd);
      rdr(A_INT);
      check("interrupt_control", INTCTL_RESET, rd);
      // reset leaves counter mode with a quiet pin, so the count stays put
      rdr(A_CNT);
      check("timer_count", COUNT_RESET, rd);
      rdr(A_BAD);
      check("unmapped rresp", {6'h0, RESP_SLVERR}, {6'h0, rs});
      wr(A_BAD, 8'h55, 4'h1);
      check("unmapped bresp", {6'h0, RESP_SLVERR}, {6'h0, rs});
      // timer mode, prescaler with the watchdog
      wr(A_OPT, 8'h08, 4'h1);
      check("mapped bresp", {6'h0, RESP_OKAY}, {6'h0, rs});
      wr(A_CNT, 8'h40, 4'h1);
      rdr(A_CNT);
      check("count held after write", 8'h40, rd);
      repeat (100) @(posedge aclk);
      rdr(A_CNT);
      near("count per instruction", 8'h56, 8'h5b);
      // overflow sets the flag; request follows the enable
      wr(A_CNT, 8'hfe, 4'h1);
      repeat (30) @(posedge aclk);
      rdr(A_INT);
      check("overflow flag", 8'h04, rd);
      check("irq masked", 8'h00, {7'h0, overflow_irq});
      wr(A_INT, 8'h24, 4'h1);
      repeat (2) @(posedge aclk);
      check("irq enabled", 8'h01, {7'h0, overflow_irq});
      repeat (20) @(posedge aclk);
      rdr(A_INT);
      check("flag kept by hardware", 8'h24, rd);
      wr(A_INT, 8'h00, 4'h1);
      repeat (2) @(posedge aclk);
      check("irq after clear", 8'h00, {7'h0, overflow_irq});
      // sleep stops the count at the edge of wrapping
      sleep_active <= 1'b1;
      wr(A_CNT, 8'hfe, 4'h1);
      repeat (60) @(posedge aclk);
      rdr(A_CNT);
      check("count in sleep", 8'hfe, rd);
      rdr(A_INT);
      check("no overflow in sleep", 8'h00, rd);
      sleep_active <= 1'b0;
      // prescaler to timer at 1:2, watchdog then undivided
      wr(A_OPT, 8'h00, 4'h1);
      wr(A_CNT, 8'h00, 4'h1);
      repeat (200) @(posedge aclk);
      rdr(A_CNT);
      near("prescaled count", 8'h16, 8'h1b);
      base = wd_pulses;
      ticks(4);
      check("watchdog bypass", 8'h04, 8'(wd_pulses - base));
      // prescaler back to the watchdog at 1:8
      wr(A_OPT, 8'h0b, 4'h1);
      base = wd_pulses;
      ticks(16);
      check("watchdog divided", 8'h02, 8'(wd_pulses - base));
      // counter mode: four rising and four falling edges per pin run
      wr(A_OPT, 8'h28, 4'h1);
      wr(A_CNT, 8'h00, 4'h1);
      pins();
      rdr(A_CNT);
      check("rising edges", 8'h04, rd);
      wr(A_OPT, 8'h38, 4'h1);
      wr(A_CNT, 8'h00, 4'h1);
      pins();
      rdr(A_CNT);
      check("falling edges", 8'h04, rd);
      wr(A_CNT, 8'h10, 4'h0);
      rdr(A_CNT);
      check("masked store", 8'h04, rd);
      results();
   end
endmodule : tmc_timer_bench
